/* File: design/uart_pkg.sv */
// Package for the serial unit: register map, field positions, reset values,
// bus carriers and receiver states.
// Assumes a 32-bit APB master and a single 25 MHz clock.
package uart_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] MODE_OFS      = 8'h00;
    localparam logic [7:0] RX_ERR_OFS    = 8'h04;
    localparam logic [7:0] TX_STATUS_OFS = 8'h08;
    localparam logic [7:0] DIVISOR_OFS   = 8'h0C;
    localparam logic [7:0] TX_BUF_OFS    = 8'h10;
    localparam logic [7:0] RX_BUF_OFS    = 8'h14;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int POWER_BIT  = 7;
    localparam int TX_EN_BIT  = 6;
    localparam int RX_EN_BIT  = 5;
    localparam int PAR_HI_BIT = 4;
    localparam int PAR_LO_BIT = 3;
    localparam int LEN8_BIT   = 2;
    localparam int STOP2_BIT  = 1;
    localparam int MERGE_BIT  = 0;
    localparam int FULL_BIT   = 1;
    localparam int SHIFT_BIT  = 0;
    localparam int PERR_BIT   = 2;
    localparam int FERR_BIT   = 1;
    localparam int OVR_BIT    = 0;

    localparam logic [7:0] MODE_RESET    = 8'h01;
    localparam logic [7:0] DIVISOR_RESET = 8'hFF;
    localparam logic [7:0] RX_BUF_RESET  = 8'hFF;
    localparam logic [7:0] DIVISOR_MIN   = 8'h08;

    // Parity type encodings.
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD  = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;

    // ************************************************************
    // Carriers and states
    // ************************************************************
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } rx_state_t;

endpackage : uart_pkg

/* File: design/uart_unit.sv */
// Serial unit with buffered transmitter, start-bit checking receiver,
// receive error flags and an APB register file.
// Assumes the base clock is clk_in; the remote node drives the receive pin
// asynchronously and the APB master follows the usual two-phase protocol.
`timescale 1ns/1ps

// How it works
// - Transmit buffer frees as soon as the shifter loads, so frames abut.
// - Transmit status bit 1 is the buffer-full flag; 1 forbids writing.
// - Transmit status bit 0 is the shifter-busy flag; 0 means done.
// - Back to back the full and busy flags pass 01, 11, then 01.
// - Reception samples the pin only with power and receive enable set.
// - Falling edge starts the counter; pin low after divisor is a start.
// - Bits shift in at baud rate; stop bit copies data and signals done.
// - An overrun leaves the receive buffer untouched.
// - Parity error is reported only when the frame completes.
// - The receiver checks one stop bit only and ignores a second.
// - Parity mismatch against odd or even parity sets the parity flag.
// - A low level at the stop-bit sample sets the framing flag.
// - A frame completing with the buffer unread sets the overrun flag.
// - Any error flag set by a frame raises an error interrupt when merge select is 0.
// - Reading the error status register clears all its bits.
// - With merge select 0 errors go on the separate error line.
// - Clearing receive enable returns the receiver to idle.
module uart_unit (
    input  wire logic              clk_in,
    input  wire logic              resetn_in,
    input  wire uart_pkg::apb_req_t apb_in,
    output uart_pkg::apb_rsp_t     apb_out,
    input  wire logic              serial_in_pin_in,
    output logic                   serial_out_pin_out,
    output logic                   tx_complete_irq_out,
    output logic                   rx_complete_irq_out,
    output logic                   rx_error_irq_out
);
    import uart_pkg::*;

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0]  operation_mode_register;
    logic [7:0]  baud_divisor;
    logic [7:0]  transmit_buffer;
    logic [11:0] transmit_shifter;
    logic [3:0]  tx_bits_left;
    logic [8:0]  tx_count;
    logic        tx_buffer_full_flag;
    logic        tx_shift_active_flag;
    logic [8:0]  receive_shifter;
    logic [7:0]  receive_buffer;
    logic        rx_unread;
    logic [2:0]  receive_error_status;
    logic [3:0]  rx_index;
    logic [8:0]  rx_count;
    rx_state_t   rx_state;
    logic        rx_sync1;
    logic        rx_sync2;
    logic        rx_sync3;
    logic        rx_level;
    logic        rx_prev;
    logic        pready;

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire        access_done = apb_in.psel & apb_in.penable & pready;
    wire        wr_done     = access_done & apb_in.pwrite;
    wire        rd_done     = access_done & ~apb_in.pwrite;
    wire [7:0]  addr        = apb_in.paddr;
    wire        sel_mode    = (addr == MODE_OFS);
    wire        sel_err     = (addr == RX_ERR_OFS);
    wire        sel_status  = (addr == TX_STATUS_OFS);
    wire        sel_div     = (addr == DIVISOR_OFS);
    wire        sel_txbuf   = (addr == TX_BUF_OFS);
    wire        sel_rxbuf   = (addr == RX_BUF_OFS);
    wire        mapped      = sel_mode | sel_err | sel_status | sel_div
                            | sel_txbuf | sel_rxbuf;
    wire [7:0]  status_byte = {6'h00, tx_buffer_full_flag,
                               tx_shift_active_flag};
    wire [7:0]  read_byte   =
        sel_mode   ? operation_mode_register :
        sel_err    ? {5'h00, receive_error_status} :
        sel_status ? status_byte :
        sel_div    ? baud_divisor :
        sel_rxbuf  ? receive_buffer : 8'h00;
    wire        err_read    = rd_done & sel_err;
    wire        rxbuf_read  = rd_done & sel_rxbuf;
    wire        tx_buf_wr   = wr_done & sel_txbuf;

    // ************************************************************
    // Mode decode and bit timing
    // ************************************************************
    wire        power    = operation_mode_register[POWER_BIT];
    wire        tx_run   = power & operation_mode_register[TX_EN_BIT];
    wire        rx_run   = power & operation_mode_register[RX_EN_BIT];
    wire [1:0]  par_type = operation_mode_register[PAR_HI_BIT:PAR_LO_BIT];
    wire        len8     = operation_mode_register[LEN8_BIT];
    wire        stop2    = operation_mode_register[STOP2_BIT];
    wire        merge    = operation_mode_register[MERGE_BIT];
    wire        has_par  = (par_type != PAR_NONE);
    // Divisors below the minimum would leave too few samples per bit.
    wire [7:0]  div_eff  = (baud_divisor < DIVISOR_MIN) ? DIVISOR_MIN
                                                        : baud_divisor;
    wire [8:0]  half_m1  = {1'b0, div_eff} - 9'h001;
    wire [8:0]  full_m1  = {div_eff, 1'b0} - 9'h001;

    // ************************************************************
    // Transmit frame assembly
    // ************************************************************
    function automatic logic [11:0] build_frame(input logic [7:0] data);
        logic [11:0] frame;
        logic        par_bit;
        frame   = 12'hFFF;
        par_bit = len8 ? ^data : ^data[6:0];
        frame[0] = 1'b0;
        if (len8) begin
            frame[8:1] = data;
        end else begin
            frame[7:1] = data[6:0];
        end
        if (par_type == PAR_ZERO) begin
            par_bit = 1'b0;
        end else if (par_type == PAR_ODD) begin
            par_bit = ~par_bit;
        end
        if (has_par) begin
            frame[len8 ? 9 : 8] = par_bit;
        end
        return frame;
    endfunction : build_frame

    wire [3:0]  tx_len   = 4'h9 + {3'h0, len8} + {3'h0, has_par}
                         + {3'h0, stop2};
    wire        tx_bit_end = tx_shift_active_flag & (tx_count == full_m1);
    wire        tx_last    = tx_bit_end & (tx_bits_left == 4'h1);
    wire        tx_load    = tx_buffer_full_flag
                           & (~tx_shift_active_flag | tx_last);

    // ************************************************************
    // Transmitter
    // ************************************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            transmit_buffer      <= 8'h00;
            transmit_shifter     <= 12'hFFF;
            tx_bits_left         <= 4'h0;
            tx_count             <= 9'h000;
            tx_buffer_full_flag  <= 1'b0;
            tx_shift_active_flag <= 1'b0;
            tx_complete_irq_out  <= 1'b0;
            serial_out_pin_out   <= 1'b1;
        end else if (!tx_run) begin
            tx_buffer_full_flag  <= 1'b0;
            tx_shift_active_flag <= 1'b0;
            tx_count             <= 9'h000;
            tx_complete_irq_out  <= 1'b0;
            serial_out_pin_out   <= 1'b1;
        end else begin
            tx_complete_irq_out <= tx_last;
            if (tx_load) begin
                // Loading frees the buffer at once for the next byte.
                transmit_shifter     <= build_frame(transmit_buffer);
                tx_bits_left         <= tx_len;
                tx_count             <= 9'h000;
                tx_shift_active_flag <= 1'b1;
                tx_buffer_full_flag  <= 1'b0;
            end else if (tx_last) begin
                tx_shift_active_flag <= 1'b0;
            end else if (tx_bit_end) begin
                transmit_shifter <= {1'b1, transmit_shifter[11:1]};
                tx_bits_left     <= tx_bits_left - 4'h1;
                tx_count         <= 9'h000;
            end else if (tx_shift_active_flag) begin
                tx_count <= tx_count + 9'h001;
            end
            if (tx_buf_wr) begin
                // A write while full overwrites; software must avoid it.
                transmit_buffer     <= apb_in.pwdata[7:0];
                tx_buffer_full_flag <= 1'b1;
            end
            serial_out_pin_out <= tx_shift_active_flag ? transmit_shifter[0]
                                                       : 1'b1;
        end
    end

    // ************************************************************
    // Receive pin synchroniser and filter
    // ************************************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_sync1 <= 1'b1;
            rx_sync2 <= 1'b1;
            rx_sync3 <= 1'b1;
            rx_level <= 1'b1;
            rx_prev  <= 1'b1;
        end else begin
            rx_sync1 <= serial_in_pin_in;
            rx_sync2 <= rx_sync1;
            rx_sync3 <= rx_sync2;
            // The input reads high while the unit is powered down.
            if (!power) begin
                rx_level <= 1'b1;
            end else if (rx_sync2 == rx_sync3) begin
                rx_level <= rx_sync3;
            end
            rx_prev <= rx_level;
        end
    end

    // ************************************************************
    // Receiver decode
    // ************************************************************
    wire [3:0]  rx_nbits   = 4'h7 + {3'h0, len8} + {3'h0, has_par};
    wire        fall_edge  = rx_prev & ~rx_level;
    wire        half_hit   = (rx_count == half_m1);
    wire        full_hit   = (rx_count == full_m1);
    wire [7:0]  rx_data    = len8 ? receive_shifter[7:0]
                                  : {1'b0, receive_shifter[6:0]};
    wire        rx_par_bit = len8 ? receive_shifter[8] : receive_shifter[7];
    wire        ones_odd   = ^rx_data ^ rx_par_bit;
    wire        par_bad    = ((par_type == PAR_EVEN) & ones_odd)
                           | ((par_type == PAR_ODD) & ~ones_odd);
    wire        rx_finish  = (rx_state == RX_STOP) & full_hit;
    wire        frame_bad  = ~rx_level;
    wire        overrun    = rx_unread;
    wire [2:0]  new_err    = rx_finish ? {par_bad, frame_bad, overrun}
                                       : 3'h0;
    wire        any_err    = |new_err;

    // ************************************************************
    // Receiver
    // ************************************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_state        <= RX_IDLE;
            rx_count        <= 9'h000;
            rx_index        <= 4'h0;
            receive_shifter <= 9'h000;
        end else if (!rx_run) begin
            rx_state <= RX_IDLE;
            rx_count <= 9'h000;
            rx_index <= 4'h0;
        end else begin
            case (rx_state)
                RX_IDLE: begin
                    rx_count <= 9'h000;
                    if (fall_edge) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    rx_count <= rx_count + 9'h001;
                    if (half_hit) begin
                        rx_count <= 9'h000;
                        rx_index <= 4'h0;
                        rx_state <= rx_level ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    rx_count <= rx_count + 9'h001;
                    if (full_hit) begin
                        rx_count <= 9'h000;
                        receive_shifter[rx_index] <= rx_level;
                        rx_index <= rx_index + 4'h1;
                        if (rx_index == rx_nbits - 4'h1) begin
                            rx_state <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    rx_count <= rx_count + 9'h001;
                    if (full_hit) begin
                        rx_count <= 9'h000;
                        rx_state <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Receive buffer, error flags and interrupts
    // ************************************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            receive_buffer       <= RX_BUF_RESET;
            rx_unread            <= 1'b0;
            receive_error_status <= 3'h0;
            rx_complete_irq_out  <= 1'b0;
            rx_error_irq_out     <= 1'b0;
        end else if (!power) begin
            receive_buffer       <= RX_BUF_RESET;
            rx_unread            <= 1'b0;
            receive_error_status <= 3'h0;
            rx_complete_irq_out  <= 1'b0;
            rx_error_irq_out     <= 1'b0;
        end else begin
            // A new error wins over a read in the same cycle.
            receive_error_status <= (receive_error_status & ~{3{err_read}})
                                  | new_err;
            if (rx_finish && !overrun) begin
                receive_buffer <= rx_data;
                rx_unread      <= 1'b1;
            end else if (rxbuf_read) begin
                rx_unread <= 1'b0;
            end
            rx_complete_irq_out <= rx_finish & (~any_err | merge);
            rx_error_irq_out    <= rx_finish & any_err & ~merge;
        end
    end

    // ************************************************************
    // APB slave
    // ************************************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            operation_mode_register <= MODE_RESET;
            baud_divisor            <= DIVISOR_RESET;
            pready                  <= 1'b0;
            apb_out                 <= '0;
        end else begin
            // One wait state lets the read data come from a flip-flop.
            pready         <= apb_in.psel & apb_in.penable & ~pready;
            apb_out.pready <= apb_in.psel & apb_in.penable & ~pready;
            if (apb_in.psel && apb_in.penable && !pready) begin
                apb_out.prdata  <= {24'h000000, read_byte};
                apb_out.pslverr <= ~mapped;
            end else begin
                apb_out.prdata  <= 32'h00000000;
                apb_out.pslverr <= 1'b0;
            end
            if (wr_done && sel_mode) begin
                operation_mode_register <= apb_in.pwdata[7:0];
            end
            if (wr_done && sel_div) begin
                baud_divisor <= apb_in.pwdata[7:0];
            end
        end
    end

endmodule : uart_unit

/* File: bench/uart_unit_properties.sv */
// Checker for the serial unit, bound to the ports of uart_unit.
// Assumes the register map of uart_pkg and a single clock domain.
`timescale 1ns/1ps
module uart_unit_checker (
    input wire logic               clk_in,
    input wire logic               resetn_in,
    input wire uart_pkg::apb_req_t apb_in,
    input wire uart_pkg::apb_rsp_t apb_out,
    input wire logic               serial_in_pin_in,
    input wire logic               serial_out_pin_out,
    input wire logic               tx_complete_irq_out,
    input wire logic               rx_complete_irq_out,
    input wire logic               rx_error_irq_out
);
    import uart_pkg::*;
    // ************************************
    // Shadow of the mode register
    // ************************************
    logic [7:0] mode;
    logic       err_clean;
    wire done   = apb_out.pready && apb_in.psel && apb_in.penable;
    wire err_rd = done && !apb_in.pwrite && apb_in.paddr == RX_ERR_OFS;
    wire rx_on  = mode[POWER_BIT] && mode[RX_EN_BIT];
    wire rx_irq = rx_complete_irq_out || rx_error_irq_out;
    // A frame in flight may set flags again, so a clean read is only
    // expected when no receive pulse came since the previous read.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode      <= MODE_RESET;
            err_clean <= 1'b0;
        end else begin
            if (done && apb_in.pwrite && apb_in.paddr == MODE_OFS)
                mode <= apb_in.pwdata[7:0];
            err_clean <= err_rd || (err_clean && !rx_irq);
        end
    end
    // ************************************
    // Properties
    // ************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence access_start;
        apb_in.psel && $rose(apb_in.penable);
    endsequence
    sequence fresh_err_read;
        err_clean && err_rd;
    endsequence
    apb_answer_a: assert property (access_start |=> apb_out.pready)
        else $error("APB answer missing");
    decode_err_a: assert property (done |-> apb_out.pslverr ==
        (apb_in.paddr > RX_BUF_OFS || apb_in.paddr[1:0] != 2'h0))
        else $error("APB error response wrong");
    err_split_a: assert property (
        !mode[MERGE_BIT] && rx_error_irq_out |-> !rx_complete_irq_out)
        else $error("Error and completion pulsed together");
    err_merge_a: assert property (
        mode[MERGE_BIT] |-> !rx_error_irq_out)
        else $error("Separate error line used while merged");
    rx_quiet_a: assert property (
        !rx_on ##1 !rx_on |-> !rx_irq)
        else $error("Receive pulse while reception is off");
    err_clear_a: assert property (
        fresh_err_read |-> apb_out.prdata[2:0] == 3'h0)
        else $error("Error status not cleared by read");
    rx_pulse_a: assert property (
        rx_complete_irq_out |=> !rx_complete_irq_out)
        else $error("Receive completion held");
    tx_idle_a: assert property (
        !mode[POWER_BIT] ##1 !mode[POWER_BIT] |-> serial_out_pin_out)
        else $error("Transmit line low while powered off");
    start_width_a: assert property (
        $fell(serial_out_pin_out) |-> !serial_out_pin_out [*8])
        else $error("Start bit too short");
endmodule : uart_unit_checker

bind uart_unit uart_unit_checker u_uart_unit_checker (
    .clk_in(clk_in), .resetn_in(resetn_in), .apb_in(apb_in),
    .apb_out(apb_out), .serial_in_pin_in(serial_in_pin_in),
    .serial_out_pin_out(serial_out_pin_out),
    .tx_complete_irq_out(tx_complete_irq_out),
    .rx_complete_irq_out(rx_complete_irq_out),
    .rx_error_irq_out(rx_error_irq_out)
);

/* File: bench/remote_node.sv */
// Remote serial node: sends frames on its line and decodes the other one.
// Assumes 8 data bits, LSB first, and BIT_CLKS clocks per bit.
`timescale 1ns/1ps
module remote_node #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic clk_in,
    input  wire logic line_in,
    output logic      line_out
);
    logic [7:0] got[$];
    logic [7:0] shift;
    initial line_out = 1'b1;
    // The line rests high between frames, as an idle serial line does.
    task automatic send(input logic [7:0] d, input logic has_par,
                        input logic par, input logic stop);
        logic [10:0] bits;
        int          n;
        bits = {stop, par, d, 1'b0};
        n = has_par ? 11 : 10;
        if (!has_par) bits[9] = stop;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            line_out <= bits[i];
            repeat (BIT_CLKS - 1) @(posedge clk_in);
        end
        @(posedge clk_in);
        line_out <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk_in);
    endtask : send
    // Decoder samples each bit at its centre.
    initial forever begin
        @(negedge line_in);
        repeat (BIT_CLKS + BIT_CLKS / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            shift[i] = line_in;
            repeat (BIT_CLKS) @(posedge clk_in);
        end
        got.push_back(shift);
    end
endmodule : remote_node

/* File: bench/uart_tx_buffering_rx_errors_test.sv */
// Self-checking bench for the serial unit over APB and both serial lines.
// Assumes uart_unit, remote_node and the bound checker.
`timescale 1ns/1ps
module uart_tx_buffering_rx_errors_test;
    import uart_pkg::*;
    localparam int BT = 16;
    logic     clk_in = 1'b0;
    logic     resetn_in = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    logic     rx_line, tx_line, txc, rxc, rxe, last_err;
    int       errors = 0, n_compared = 0, cycles = 0;
    int       n_txc = 0, n_rxc = 0, n_rxe = 0, n_rx = 0;
    uart_unit u_uart_unit (
        .clk_in(clk_in), .resetn_in(resetn_in), .apb_in(req),
        .apb_out(rsp), .serial_in_pin_in(rx_line),
        .serial_out_pin_out(tx_line), .tx_complete_irq_out(txc),
        .rx_complete_irq_out(rxc), .rx_error_irq_out(rxe));
    remote_node #(.BIT_CLKS(BT)) u_remote_node (
        .clk_in(clk_in), .line_in(tx_line), .line_out(rx_line));
    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (txc === 1'b1) n_txc++;
        if (rxc === 1'b1) n_rxc++;
        if (rxe === 1'b1) n_rxe++;
        if (rxc === 1'b1 || rxe === 1'b1) n_rx++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_in);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
        @(posedge clk_in);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        last_err = rsp.pslverr;
        chk({31'h0, rsp.pready}, 32'h1);
        req <= '0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        apb(1'b1, a, {24'h0, d}, rd);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] rd;
        apb(1'b0, a, 32'h0, rd);
        chk(rd, {24'h0, e});
    endtask : rd_chk
    task automatic wait_ev(ref int cnt, input int was);
        int n;
        n = 0;
        while (cnt == was && n < 600) begin
            @(posedge clk_in);
            n++;
        end
        chk(cnt != was, 1);
        repeat (2) @(posedge clk_in);
    endtask : wait_ev
    // Quiet frames get a fixed wait since no pulse marks their end.
    task automatic frame(input logic [7:0] d, input logic hp, input logic p,
                         input logic stop, input int ec, input int ee);
        int c0, e0, a0;
        c0 = n_rxc;
        e0 = n_rxe;
        a0 = n_rx;
        u_remote_node.send(d, hp, p, stop);
        if (ec + ee > 0) wait_ev(n_rx, a0);
        else repeat (3 * BT) @(posedge clk_in);
        chk(n_rxc - c0, ec);
        chk(n_rxe - e0, ee);
    endtask : frame
    task automatic t_regs;
        logic [31:0] d;
        rd_chk(MODE_OFS, MODE_RESET);
        rd_chk(DIVISOR_OFS, DIVISOR_RESET);
        rd_chk(RX_BUF_OFS, RX_BUF_RESET);
        wr(TX_STATUS_OFS, 8'h03);
        rd_chk(TX_STATUS_OFS, 8'h00);
        apb(1'b0, 8'h18, 32'h0, d);
        chk({31'h0, last_err}, 32'h1);
    endtask : t_regs
    task automatic t_tx;
        wr(DIVISOR_OFS, 8'h08);
        wr(MODE_OFS, 8'hE4);
        wr(TX_BUF_OFS, 8'hA5);
        rd_chk(TX_STATUS_OFS, 8'h01);
        wr(TX_BUF_OFS, 8'h3C);
        rd_chk(TX_STATUS_OFS, 8'h03);
        wait_ev(n_txc, 0);
        rd_chk(TX_STATUS_OFS, 8'h01);
        wait_ev(n_txc, 1);
        rd_chk(TX_STATUS_OFS, 8'h00);
        chk(u_remote_node.got.size(), 2);
        chk(u_remote_node.got[0], 8'hA5);
        chk(u_remote_node.got[1], 8'h3C);
    endtask : t_tx
    task automatic t_rx;
        for (int p = 0; p < 4; p++) begin
            wr(MODE_OFS, 8'hE4 | 8'(p << 3));
            frame(8'h5A, p != 0, 1'b1, 1'b1, p != 3, p == 3);
            rd_chk(RX_ERR_OFS, p == 3 ? 8'h04 : 8'h00);
            rd_chk(RX_ERR_OFS, 8'h00);
            rd_chk(RX_BUF_OFS, 8'h5A);
        end
        wr(MODE_OFS, 8'hE5);
        frame(8'hC3, 1'b0, 1'b0, 1'b0, 1, 0);
        rd_chk(RX_ERR_OFS, 8'h02);
        rd_chk(RX_BUF_OFS, 8'hC3);
        wr(MODE_OFS, 8'hE4);
        frame(8'h11, 1'b0, 1'b0, 1'b1, 1, 0);
        frame(8'h22, 1'b0, 1'b0, 1'b1, 0, 1);
        rd_chk(RX_ERR_OFS, 8'h01);
        rd_chk(RX_BUF_OFS, 8'h11);
        wr(MODE_OFS, 8'hE2);
        frame(8'hB6, 1'b0, 1'b0, 1'b1, 1, 0);
        rd_chk(RX_ERR_OFS, 8'h00);
        rd_chk(RX_BUF_OFS, 8'h36);
        wr(MODE_OFS, 8'hC4);
        frame(8'h99, 1'b0, 1'b0, 1'b1, 0, 0);
        wr(MODE_OFS, 8'hE4);
        frame(8'h66, 1'b0, 1'b0, 1'b1, 1, 0);
        rd_chk(RX_BUF_OFS, 8'h66);
    endtask : t_rx
    task automatic report_and_stop;
        $display("Compared %0d values, %0d errors", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        t_regs();
        t_tx();
        t_rx();
        report_and_stop();
    end
endmodule : uart_tx_buffering_rx_errors_test
